// file: core/rim_ref_monitor.sv
// module: reference input monitor top with byte registers on an APB slave
//
// Contract
// - inner tolerance is 20 bits, 0x00a..0x8ff
// - setting N allows fractional error one over N
// - valid only after programmed unfaulted milliseconds
// - phase lock threshold 24 bits, 700 ps
// - phase lock fill and drain rates, default ten
// - frequency lock threshold separate, 700 ps
// - frequency lock fill and drain rates, ten
// - phase step threshold 28 bits, zero disables
//
// Chosen here: register access over APB.
`default_nettype none
module rim_ref_monitor #(
   parameter int MS_CYCLES = rim_pkg::RIM_MS_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic meas_stb,
   input wire logic [31:0] meas_period,
   input wire logic [31:0] nom_period,
   input wire logic pd_stb,
   input wire logic [27:0] pd_phase_err_ps,
   input wire logic [27:0] pd_freq_err_ps,
   output logic ref_valid,
   output logic ref_faulted,
   output logic phase_locked,
   output logic freq_locked,
   output logic phase_step_flag
);
   typedef struct packed {
      logic [rim_pkg::RIM_NCFG-1:0][7:0] cfg;
      logic step;
      logic vrestart;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } rim_top_st_t;
   rim_top_st_t st_r;
   rim_top_st_t st_nxt;

   // register map by index; byte address is four times the index
   //   309..30b  inner window divisor, bits 19:0, lowest byte first
   //   30c..30e  outer window divisor, bits 19:0
   //   30f..310  clean time before valid, in milliseconds
   //   311..313  phase lock limit in ps
   //   314, 315  phase lock fill and drain steps
   //   316..318  frequency lock limit in ps
   //   319, 31a  frequency lock fill and drain steps
   //   31b..31e  jump limit in ps, bits 27:0, zero turns it off
   //   31f       status; writing one to bit 4 clears the jump flag
   // multi-byte fields are not staged: a half-written value acts at once,
   // so software should not let the monitors run while it rewrites them

   logic [9:0] idx;
   logic [4:0] sel;
   logic hit;
   logic is_stat;
   logic setup;
   logic access;
   logic [4:0] status;
   logic [27:0] jump_thr;
   logic step_hit;
   logic fm_faulted;
   logic fm_valid;
   logic [1:0] locked_w;

   // =====================================================================
   // address decode: one register per aligned word
   assign idx = paddr[11:2];
   always_comb begin
      hit = 1'b0;
      sel = 5'h00;
      for (int k = 0; k < rim_pkg::RIM_NCFG; k++) begin
         if (idx == rim_pkg::RIM_CFG_IDX[k]) begin
            hit = 1'b1;
            sel = 5'(k);
         end
      end
   end
   assign is_stat = idx == rim_pkg::RIM_IDX_STAT;
   assign setup = psel && !penable;
   assign access = psel && penable && st_r.pready;

   // a zero threshold switches step detection off completely
   assign jump_thr = {st_r.cfg[rim_pkg::RIM_K_JUMP + 3][3:0],
      st_r.cfg[rim_pkg::RIM_K_JUMP + 2], st_r.cfg[rim_pkg::RIM_K_JUMP + 1],
      st_r.cfg[rim_pkg::RIM_K_JUMP]};
   assign step_hit = pd_stb && (jump_thr != 28'h0000000)
      && (pd_phase_err_ps > jump_thr);

   // status bits: 0 valid, 1 faulted, 2 phase lock, 3 frequency lock, 4 jump
   assign status = {st_r.step, locked_w[1], locked_w[0], fm_faulted, fm_valid};

   // =====================================================================
   // bus slave and register file; answer comes in the first access cycle
   // setup at edge n loads read data and pready; the access phase sees them
   // at edge n+1, where a write lands and pready drops again, so
   // every transfer takes exactly one access cycle with no wait states
   always_comb begin
      st_nxt = st_r;
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      st_nxt.vrestart = 1'b0;
      if (setup) begin
         st_nxt.pready = 1'b1;
         st_nxt.pslverr = !(hit || is_stat);
         if (hit) begin
            st_nxt.prdata = {24'h000000, st_r.cfg[sel]};
         end else if (is_stat) begin
            st_nxt.prdata = {27'h0000000, status};
         end else begin
            st_nxt.prdata = 32'h00000000;
         end
      end
      if (access && pwrite && hit) begin
         // reserved bits are masked so they always read back as zero
         st_nxt.cfg[sel] = pwdata[7:0] & rim_pkg::RIM_CFG_MASK[sel];
         // new validation time restarts the clean-time count
         if (sel == 5'(rim_pkg::RIM_K_VTIME) || sel == 5'(rim_pkg::RIM_K_VTIME + 1)) begin
            st_nxt.vrestart = 1'b1;
         end
      end
      // write one to clear; a step in the same cycle wins over the clear
      if (access && pwrite && is_stat && pwdata[rim_pkg::RIM_ST_STEP]) begin
         st_nxt.step = 1'b0;
      end
      if (step_hit) begin
         st_nxt.step = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r <= '{cfg: rim_pkg::RIM_CFG_RST, step: 1'b0, vrestart: 1'b0,
            prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign phase_step_flag = st_r.step;
   assign ref_valid = fm_valid;
   assign ref_faulted = fm_faulted;
   assign phase_locked = locked_w[0];
   assign freq_locked = locked_w[1];

   // =====================================================================
   // frequency monitor and validation timer
   rim_freq_mon #(.MS_CYCLES(MS_CYCLES)) u_fmon (
      .clk(clk),
      .sys_rst(sys_rst),
      .meas_stb(meas_stb),
      .meas_period(meas_period),
      .nom_period(nom_period),
      .inner_tol({st_r.cfg[rim_pkg::RIM_K_INNER + 2][3:0],
         st_r.cfg[rim_pkg::RIM_K_INNER + 1], st_r.cfg[rim_pkg::RIM_K_INNER]}),
      .outer_tol({st_r.cfg[rim_pkg::RIM_K_OUTER + 2][3:0],
         st_r.cfg[rim_pkg::RIM_K_OUTER + 1], st_r.cfg[rim_pkg::RIM_K_OUTER]}),
      .vtime({st_r.cfg[rim_pkg::RIM_K_VTIME + 1], st_r.cfg[rim_pkg::RIM_K_VTIME]}),
      .restart(st_r.vrestart),
      .faulted(fm_faulted),
      .valid(fm_valid)
   );

   // =====================================================================
   // lock detectors: 0 is phase, 1 is frequency, each with its own settings
   for (genvar g = 0; g < 2; g++) begin : g_det
      localparam int KT = (g == 0) ? rim_pkg::RIM_K_PTHR : rim_pkg::RIM_K_FTHR;
      localparam int KF = (g == 0) ? rim_pkg::RIM_K_PFILL : rim_pkg::RIM_K_FFILL;
      rim_lock_if lk ();
      assign lk.thresh = {st_r.cfg[KT + 2], st_r.cfg[KT + 1], st_r.cfg[KT]};
      assign lk.fill = st_r.cfg[KF];
      assign lk.drain = st_r.cfg[KF + 1];
      assign lk.stb = pd_stb;
      assign lk.err = (g == 0) ? pd_phase_err_ps : pd_freq_err_ps;
      assign locked_w[g] = lk.locked;
      rim_lock_det u_det (
         .clk(clk),
         .sys_rst(sys_rst),
         .lk(lk)
      );
   end

   // =====================================================================
   // checks
   AST_RESET_CFG: assert property (@(posedge clk)
      sys_rst |=> st_r.cfg == rim_pkg::RIM_CFG_RST && !st_r.step)
      else $error("configuration not at reset values");
   AST_READY_NEXT: assert property (@(posedge clk) disable iff (sys_rst)
      setup |=> pready ##1 !pready)
      else $error("slave did not answer in the first access cycle");
   AST_WRITE_TAKES: assert property (@(posedge clk) disable iff (sys_rst)
      access && pwrite && hit
      |=> st_r.cfg[$past(sel)] == ($past(pwdata[7:0]) & rim_pkg::RIM_CFG_MASK[$past(sel)]))
      else $error("register write not stored");
   AST_UNMAPPED: assert property (@(posedge clk) disable iff (sys_rst)
      setup && !hit && !is_stat |=> pslverr && prdata == 32'h00000000)
      else $error("unmapped access not refused");
   AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      st_r.cfg[rim_pkg::RIM_K_INNER + 2][7:4] == 4'h0
      && st_r.cfg[rim_pkg::RIM_K_OUTER + 2][7:4] == 4'h0)
      else $error("reserved tolerance bits set");
   AST_STEP_SET: assert property (@(posedge clk) disable iff (sys_rst)
      step_hit |=> phase_step_flag)
      else $error("phase step not flagged");
   AST_STEP_OFF: assert property (@(posedge clk) disable iff (sys_rst)
      jump_thr == 28'h0000000 && !st_r.step |=> !st_r.step)
      else $error("phase step flagged while detection disabled");
   AST_VRESTART: assert property (@(posedge clk) disable iff (sys_rst)
      st_r.vrestart |=> !ref_valid)
      else $error("validation not restarted after timer write");

   // an error answer is only ever given together with ready
   AST_ERR_WITH_READY: assert property (@(posedge clk) disable iff (sys_rst)
      pslverr |-> pready)
      else $error("error response without ready");

   // read data of a mapped byte is the stored byte, zero extended
   AST_READ_DATA: assert property (@(posedge clk) disable iff (sys_rst)
      setup && hit |=> prdata == {24'h000000, $past(st_r.cfg[sel])})
      else $error("read data differs from stored byte");

   // status reads return the live monitor and detector state
   AST_STATUS_READ: assert property (@(posedge clk) disable iff (sys_rst)
      setup && is_stat |=> prdata == {27'h0000000, $past(status)})
      else $error("status read data wrong");

   // a write outside the map must leave every byte alone
   AST_UNMAPPED_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
      access && pwrite && !hit |=> st_r.cfg == $past(st_r.cfg))
      else $error("unmapped write changed configuration");

   // write one clears the jump flag when no new jump arrives with it
   AST_STEP_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
      access && pwrite && is_stat && pwdata[rim_pkg::RIM_ST_STEP] && !step_hit
      |=> !phase_step_flag)
      else $error("jump flag not cleared by write one");

   COV_READ: cover property (@(posedge clk) disable iff (sys_rst)
      access && !pwrite && hit);
   COV_VALID: cover property (@(posedge clk) disable iff (sys_rst) $rose(ref_valid));
   COV_PLOCK: cover property (@(posedge clk) disable iff (sys_rst) $rose(phase_locked));
   COV_STEP: cover property (@(posedge clk) disable iff (sys_rst) $rose(phase_step_flag));
   COV_FLOCK: cover property (@(posedge clk) disable iff (sys_rst) $rose(freq_locked));
endmodule
`default_nettype wire

// file: core/rim_pkg.sv
// package: register indices, reset values and constants of the reference monitor
`default_nettype none
package rim_pkg;
   // =====================================================================
   // register map: bus byte address is four times the index
   localparam int RIM_NCFG = 22;
   localparam logic [RIM_NCFG-1:0][9:0] RIM_CFG_IDX = {
      10'h31e, 10'h31d, 10'h31c, 10'h31b, 10'h31a, 10'h319, 10'h318, 10'h317,
      10'h316, 10'h315, 10'h314, 10'h313, 10'h312, 10'h311, 10'h310, 10'h30f,
      10'h30e, 10'h30d, 10'h30c, 10'h30b, 10'h30a, 10'h309};
   localparam logic [9:0] RIM_IDX_STAT = 10'h31f;
   // reset value of each configuration byte, highest index first
   localparam logic [RIM_NCFG-1:0][7:0] RIM_CFG_RST = {
      8'h00, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h0a, 8'h00, 8'h02, 8'hbc, 8'h0a, 8'h0a,
      8'h00, 8'h02, 8'hbc, 8'h00, 8'h0a, 8'h00, 8'h00, 8'h0a, 8'h00, 8'h00, 8'h14};
   // writable bits; reserved upper nibbles read as zero
   localparam logic [RIM_NCFG-1:0][7:0] RIM_CFG_MASK = {
      8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff};
   // =====================================================================
   // byte position of each field inside the configuration array
   localparam int RIM_K_INNER = 0;
   localparam int RIM_K_OUTER = 3;
   localparam int RIM_K_VTIME = 6;
   localparam int RIM_K_PTHR = 8;
   localparam int RIM_K_PFILL = 11;
   localparam int RIM_K_FTHR = 13;
   localparam int RIM_K_FFILL = 16;
   localparam int RIM_K_JUMP = 18;
   // status register bits
   localparam int RIM_ST_VALID = 0;
   localparam int RIM_ST_FAULT = 1;
   localparam int RIM_ST_PLOCK = 2;
   localparam int RIM_ST_FLOCK = 3;
   localparam int RIM_ST_STEP = 4;
   // =====================================================================
   // timing and widths
   localparam int RIM_CLK_PERIOD_NS = 40;
   localparam int RIM_MS_NS = 1000000;
   localparam int RIM_MS_CYCLES = RIM_MS_NS / RIM_CLK_PERIOD_NS;
   localparam int RIM_ERR_W = 28;
   localparam logic [15:0] RIM_ACC_MAX = 16'h0400;
endpackage
`default_nettype wire

// file: core/rim_lock_if.sv
// interface: settings and per-cycle error feed of one lock detector
`default_nettype none
interface rim_lock_if;
   logic [23:0] thresh;
   logic [7:0] fill;
   logic [7:0] drain;
   logic stb;
   logic [27:0] err;
   logic locked;
   modport ctl (output thresh, output fill, output drain, output stb, output err,
      input locked);
   modport det (input thresh, input fill, input drain, input stb, input err,
      output locked);
endinterface
`default_nettype wire

// file: core/rim_lock_det.sv
// module: fill/drain lock detector driven once per phase detector cycle
`default_nettype none
module rim_lock_det (
   input wire logic clk,
   input wire logic sys_rst,
   rim_lock_if.det lk
);
   typedef struct packed {
      logic [15:0] acc;
      logic locked;
   } rim_ld_st_t;
   rim_ld_st_t st_r;
   rim_ld_st_t st_nxt;
   logic [16:0] up;
   logic below;

   // =====================================================================
   // accumulator: fill under threshold, drain otherwise, saturating
   always_comb begin
      st_nxt = st_r;
      up = {1'b0, st_r.acc} + {9'h000, lk.fill};
      below = lk.err < {4'h0, lk.thresh};
      if (lk.stb) begin
         if (below) begin
            st_nxt.acc = (up >= {1'b0, rim_pkg::RIM_ACC_MAX}) ? rim_pkg::RIM_ACC_MAX
               : up[15:0];
         end else if (st_r.acc > {8'h00, lk.drain}) begin
            st_nxt.acc = st_r.acc - {8'h00, lk.drain};
         end else begin
            st_nxt.acc = 16'h0000;
         end
      end
      // lock at the top, loss only once fully drained, so noise cannot chatter it
      if (st_nxt.acc == rim_pkg::RIM_ACC_MAX) begin
         st_nxt.locked = 1'b1;
      end else if (st_nxt.acc == 16'h0000) begin
         st_nxt.locked = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign lk.locked = st_r.locked;

   // =====================================================================
   // checks
   AST_LOCK_AT_TOP: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(st_r.locked) |-> st_r.acc == rim_pkg::RIM_ACC_MAX)
      else $error("lock declared below accumulator limit");
   AST_FILL_STEP: assert property (@(posedge clk) disable iff (sys_rst)
      lk.stb && below && up < {1'b0, rim_pkg::RIM_ACC_MAX}
      |=> st_r.acc == $past(up[15:0]))
      else $error("accumulator did not fill by the fill rate");
endmodule
`default_nettype wire

// file: core/rim_freq_mon.sv
// module: frequency monitor with hysteresis and the validation timer
`default_nettype none
module rim_freq_mon #(
   parameter int MS_CYCLES = rim_pkg::RIM_MS_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic meas_stb,
   input wire logic [31:0] meas_period,
   input wire logic [31:0] nom_period,
   input wire logic [19:0] inner_tol,
   input wire logic [19:0] outer_tol,
   input wire logic [15:0] vtime,
   input wire logic restart,
   output logic faulted,
   output logic valid
);
   typedef struct packed {
      logic faulted;
      logic valid;
      logic [15:0] ms_cnt;
      logic [31:0] tick;
   } rim_fm_st_t;
   rim_fm_st_t st_r;
   rim_fm_st_t st_nxt;
   logic [31:0] err;
   logic [51:0] prod_out;
   logic [51:0] prod_in;
   logic over_outer;
   logic in_inner;

   // error above 1/N of nominal is err*N > nominal, with no divider needed
   assign err = (meas_period > nom_period) ? meas_period - nom_period
      : nom_period - meas_period;
   assign prod_out = err * outer_tol;
   assign prod_in = err * inner_tol;
   assign over_outer = prod_out > {20'h00000, nom_period};
   assign in_inner = prod_in <= {20'h00000, nom_period};

   // =====================================================================
   // fault with hysteresis, then a millisecond count of clean time
   always_comb begin
      st_nxt = st_r;
      if (meas_stb) begin
         if (over_outer) begin
            st_nxt.faulted = 1'b1;
         end else if (in_inner) begin
            st_nxt.faulted = 1'b0;
         end
      end
      if (st_nxt.faulted || restart) begin
         st_nxt.ms_cnt = 16'h0000;
         st_nxt.tick = 32'h00000000;
         st_nxt.valid = 1'b0;
      end else begin
         if (st_r.tick >= 32'(MS_CYCLES - 1)) begin
            st_nxt.tick = 32'h00000000;
            if (st_r.ms_cnt != 16'hffff) begin
               st_nxt.ms_cnt = st_r.ms_cnt + 16'h0001;
            end
         end else begin
            st_nxt.tick = st_r.tick + 32'h00000001;
         end
         if (st_r.ms_cnt >= vtime) begin
            st_nxt.valid = 1'b1;
         end
      end
   end

   // unmeasured reference starts out faulted
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r <= '{faulted: 1'b1, valid: 1'b0, ms_cnt: 16'h0000, tick: 32'h00000000};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign faulted = st_r.faulted;
   assign valid = st_r.valid;

   // =====================================================================
   // checks
   AST_FAULT_SET: assert property (@(posedge clk) disable iff (sys_rst)
      meas_stb && over_outer |=> st_r.faulted)
      else $error("outer tolerance breach did not fault");
   AST_NO_VALID_FAULT: assert property (@(posedge clk) disable iff (sys_rst)
      !(st_r.valid && st_r.faulted))
      else $error("reference valid while faulted");
   AST_VALID_TIME: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(st_r.valid) |-> $past(st_r.ms_cnt) >= $past(vtime))
      else $error("valid declared before validation time");
endmodule
`default_nettype wire

// file: tb/rim_ref_src.sv
// partner model: reference source giving period measurements and detector errors
`default_nettype none
module rim_ref_src (
   input wire logic clk,
   output var logic meas_stb,
   output var logic [31:0] meas_period,
   output var logic [31:0] nom_period,
   output var logic pd_stb,
   output var logic [27:0] pd_phase_err_ps,
   output var logic [27:0] pd_freq_err_ps
);
   timeunit 1ns;
   timeprecision 1ns;
   // =====================================================================
   // idle state; nominal period fixed at 1000 units
   initial begin
      meas_stb = 1'b0;
      meas_period = 32'h0;
      nom_period = 32'h3e8;
      pd_stb = 1'b0;
      pd_phase_err_ps = 28'h0;
      pd_freq_err_ps = 28'h0;
   end
   // one measurement; the bus is scrambled after the strobe so stale data never matches
   task automatic meas(input logic [31:0] p);
      @(posedge clk);
      meas_stb <= 1'b1;
      meas_period <= p;
      @(posedge clk);
      meas_stb <= 1'b0;
      meas_period <= ~p;
      #1;
   endtask
   // n detector cycles, gap + 1 idle clocks after each one (0 leaves one)
   task automatic pd(input int n, input logic [27:0] pe, input logic [27:0] fe, input int gap);
      repeat (n) begin
         @(posedge clk);
         pd_stb <= 1'b1;
         pd_phase_err_ps <= pe;
         pd_freq_err_ps <= fe;
         @(posedge clk);
         pd_stb <= 1'b0;
         pd_phase_err_ps <= ~pe;
         pd_freq_err_ps <= ~fe;
         repeat (gap) @(posedge clk);
      end
      #1;
   endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// testbench: register, monitor, lock and step scenarios for the reference monitor
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_count++; \
   $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MS = 10;
   localparam logic [7:0] RST [22] = '{8'h14, 8'h00, 8'h00, 8'h0a, 8'h00, 8'h00, 8'h0a, 8'h00,
      8'hbc, 8'h02, 8'h00, 8'h0a, 8'h0a, 8'hbc, 8'h02, 8'h00, 8'h0a, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00};
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, meas_period, nom_period, rd;
   logic pready, pslverr, meas_stb, pd_stb, se;
   logic [27:0] perr, ferr;
   logic ref_valid, ref_faulted, phase_locked, freq_locked, phase_step_flag;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   // =====================================================================
   // design, source model, clock and hang guard
   rim_ref_monitor #(.MS_CYCLES(MS)) rim_ref_monitor_i (.clk(clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_stb(meas_stb),
      .meas_period(meas_period), .nom_period(nom_period), .pd_stb(pd_stb),
      .pd_phase_err_ps(perr), .pd_freq_err_ps(ferr), .ref_valid(ref_valid),
      .ref_faulted(ref_faulted), .phase_locked(phase_locked), .freq_locked(freq_locked),
      .phase_step_flag(phase_step_flag));
   rim_ref_src rim_ref_src_i (.clk(clk), .meas_stb(meas_stb), .meas_period(meas_period),
      .nom_period(nom_period), .pd_stb(pd_stb), .pd_phase_err_ps(perr), .pd_freq_err_ps(ferr));
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // =====================================================================
   // apb transfer; waits for pready rather than assuming the slave's latency
   task automatic apb(input logic [9:0] idx, input logic wr, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // =====================================================================
   // scenarios
   task automatic t_reset_vals();
      for (int i = 0; i < 22; i++) begin
         apb(10'h309 + 10'(i), 1'b0, 8'h00);
         `CHK("cfg reset", {24'h000000, RST[i]}, rd)
      end
      apb(10'h31f, 1'b0, 8'h00);
      `CHK("stat reset", 32'h2, rd)
      tick(0);
      `CHK("pready pulse", 1'b0, pready)
      apb(10'h308, 1'b1, 8'hff);
      `CHK("unmapped err", 1'b1, se)
      apb(10'h308, 1'b0, 8'h00);
      `CHK("unmapped data", 32'h0, rd)
   endtask
   // default windows: inner 1/20, outer 1/10, so outer stays wider
   task automatic t_hyst();
      logic [31:0] p [5] = '{32'h410, 32'h438, 32'h383, 32'h398, 32'h3b6};
      logic f [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 5; i++) begin
         rim_ref_src_i.meas(p[i]);
         tick(1);
         `CHK("faulted", f[i], ref_faulted)
      end
   endtask
   task automatic t_valid();
      int n;
      n = 0;
      while (ref_valid !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      `CHK("valid 10ms", 1'b1, (n >= 10 * MS - 1 && n <= 10 * MS + 4))
      apb(10'h30f, 1'b1, 8'h03);
      tick(2);
      `CHK("valid restart", 1'b0, ref_valid)
      n = 2;
      while (ref_valid !== 1'b1 && n < 100) begin
         tick(1);
         n++;
      end
      `CHK("valid 3ms", 1'b1, (n >= 3 * MS && n <= 3 * MS + 5))
      rim_ref_src_i.meas(32'h7d0);
      tick(2);
      `CHK("valid drop", 1'b0, ref_valid)
      apb(10'h31f, 1'b0, 8'h00);
      `CHK("stat fault", 32'h2, rd)
   endtask
   // fill 128 reaches the 0x400 top in 8 cycles; drain 255 empties it in 5
   task automatic t_lock(input logic [9:0] b, input logic fq);
      logic [27:0] thr;
      logic [27:0] big;
      thr = fq ? 28'h00102bc : 28'h00002bc;
      big = 28'hfffffff;
      if (fq) begin
         apb(b + 10'h2, 1'b1, 8'h01);
      end
      apb(b + 10'h3, 1'b1, 8'h80);
      apb(b + 10'h4, 1'b1, 8'hff);
      rim_ref_src_i.pd(7, fq ? big : thr - 1, fq ? thr - 1 : big, 0);
      `CHK("lock early", 1'b0, fq ? freq_locked : phase_locked)
      rim_ref_src_i.pd(1, fq ? big : thr - 1, fq ? thr - 1 : big, 1);
      `CHK("lock top", 1'b1, fq ? freq_locked : phase_locked)
      `CHK("other lock", 1'b0, fq ? phase_locked : freq_locked)
      rim_ref_src_i.pd(4, fq ? big : thr, fq ? thr : big, 3);
      `CHK("lock held", 1'b1, fq ? freq_locked : phase_locked)
      rim_ref_src_i.pd(1, fq ? big : thr, fq ? thr : big, 1);
      `CHK("lock lost", 1'b0, fq ? freq_locked : phase_locked)
   endtask
   task automatic t_step();
      `CHK("step off", 1'b0, phase_step_flag)
      apb(10'h31e, 1'b1, 8'hf1);
      apb(10'h31e, 1'b0, 8'h00);
      `CHK("step b3", 32'h1, rd)
      rim_ref_src_i.pd(1, 28'h1000000, 28'h0, 1);
      `CHK("step equal", 1'b0, phase_step_flag)
      rim_ref_src_i.pd(1, 28'h1000001, 28'h0, 1);
      `CHK("step over", 1'b1, phase_step_flag)
      apb(10'h31f, 1'b1, 8'h10);
      tick(1);
      `CHK("step clear", 1'b0, phase_step_flag)
   endtask
   // last, since it leaves every field at its maximum
   task automatic t_rw();
      for (int i = 0; i < 22; i++) begin
         apb(10'h309 + 10'(i), 1'b1, 8'hff);
         apb(10'h309 + 10'(i), 1'b0, 8'h00);
         `CHK("cfg rw", {24'h0, (i == 2 || i == 5 || i == 21) ? 8'h0f : 8'hff}, rd)
      end
   endtask
   // =====================================================================
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      tick(1);
      t_reset_vals();
      t_hyst();
      t_valid();
      t_lock(10'h311, 1'b0);
      t_lock(10'h316, 1'b1);
      t_step();
      t_rw();
      wrap_up();
   end
endmodule
`default_nettype wire
